//--- hdl/dvssp_top.v
// voltage-select setpoint register bank with per-master target outputs
`timescale 1ns/1ns
`include "dvssp_defines.vh"
module dvssp_top #(
  parameter MASTERS = `DVSSP_MASTERS, // number of buck masters
  parameter CODE_W = `DVSSP_CODE_W // setpoint code width
) (
  input wire clk_sys, // system clock, 25 MHz
  input wire reset_n, // power-on reset, active low, asynchronous
  input wire voltage_select_pin, // general_purpose_input carrying the select level
  input wire [7:0] reg_addr, // register offset from the serial interface
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  input wire [3*CODE_W-1:0] ext_high_code, // high codes of masters 1 to 3, held elsewhere
  output reg [7:0] reg_rdata, // read data, valid with reg_rvalid
  output reg reg_rvalid, // read answer pulse
  output reg voltage_select_level, // filtered select level
  output reg [MASTERS*CODE_W-1:0] target_code, // active code per master
  output reg [MASTERS*`DVSSP_MV_W-1:0] target_mv // active target per master in mV
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select level from the pin

  wire sel_level;

  dvssp_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .pin_in(voltage_select_pin),
    .level_q(sel_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // index of a sleep register, or MASTERS when the offset is not one
  function [2:0] sleep_index;
    input [7:0] addr;
    begin
      case (addr)
        `DVSSP_ADDR_M1_SLEEP: sleep_index = 3'd0;
        `DVSSP_ADDR_M2_SLEEP: sleep_index = 3'd1;
        `DVSSP_ADDR_M3_SLEEP: sleep_index = 3'd2;
        `DVSSP_ADDR_M4_SLEEP: sleep_index = 3'd3;
        default: sleep_index = 3'd4;
      endcase
    end
  endfunction

  // linear map; 0xff lands on 1525 mV with no clamping needed
  function [`DVSSP_MV_W-1:0] code_to_mv;
    input [7:0] code;
    reg [`DVSSP_MV_W-1:0] wide;
    begin
      wide = {3'h0, code};
      code_to_mv = `DVSSP_MV_BASE + wide * `DVSSP_MV_STEP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // setpoint registers

  reg [7:0] high4_q;
  reg [7:0] sleep_q [0:3];
  integer i;

  wire [2:0] wr_idx;
  wire high_hit;
  wire high_we;
  wire [3:0] sleep_we;

  assign wr_idx = sleep_index(reg_addr);
  assign high_hit = (reg_addr == `DVSSP_ADDR_M4_HIGH);
  assign high_we = reg_wr & high_hit;

  // one write enable per sleep register, decoded once from the offset
  genvar w;
  generate
    for (w = 0; w < 4; w = w + 1) begin : g_we
      assign sleep_we[w] = reg_wr & (wr_idx == w);
    end
  endgenerate

  // master 4 high code; every code is accepted as written, nothing to reject
  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      high4_q <= `DVSSP_RST_HIGH;
    end else if (high_we) begin
      high4_q <= reg_wdata;
    end
  end

  // sleep codes of masters 1 to 4 kept in one process so the array has one driver
  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (i = 0; i < 4; i = i + 1) begin
        sleep_q[i] <= `DVSSP_RST_SLEEP;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (sleep_we[i]) begin
          sleep_q[i] <= reg_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: answer one cycle after the strobe

  reg [7:0] rdata_d;

  // unmapped offsets read as zero; the host gets no error flag for them
  always @* begin
    case (reg_addr)
      `DVSSP_ADDR_M4_HIGH: rdata_d = high4_q;
      `DVSSP_ADDR_M1_SLEEP: rdata_d = sleep_q[0];
      `DVSSP_ADDR_M2_SLEEP: rdata_d = sleep_q[1];
      `DVSSP_ADDR_M3_SLEEP: rdata_d = sleep_q[2];
      `DVSSP_ADDR_M4_SLEEP: rdata_d = sleep_q[3];
      default: rdata_d = `DVSSP_RDATA_UNMAPPED;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target selection per master

  genvar g;
  generate
    for (g = 0; g < MASTERS; g = g + 1) begin : g_master
      wire [7:0] high_code;
      wire [7:0] sel_code;
      if (g == MASTERS - 1) begin : g_own
        assign high_code = high4_q;
      end else begin : g_ext
        assign high_code = ext_high_code[g*CODE_W +: CODE_W];
      end
      // masters 1 to 3 take their high code from outside this bank
      assign sel_code = sel_level ? high_code : sleep_q[g];

      // recomputed every cycle, so a rewrite or a select flip shows
      // on the next edge with no host action
      always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
          target_code[g*CODE_W +: CODE_W] <= `DVSSP_RST_SLEEP;
        end else begin
          target_code[g*CODE_W +: CODE_W] <= sel_code;
        end
      end

      // the millivolt copy is taken from the same selected code in the
      // same cycle, so code and millivolts never disagree at an output
      always @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
          target_mv[g*`DVSSP_MV_W +: `DVSSP_MV_W] <= code_to_mv(`DVSSP_RST_SLEEP);
        end else begin
          target_mv[g*`DVSSP_MV_W +: `DVSSP_MV_W] <= code_to_mv(sel_code);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // level reported back as a flop copy

  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      voltage_select_level <= 1'b0;
    end else begin
      voltage_select_level <= sel_level;
    end
  end

endmodule

//--- pkg/dvssp_defines.vh
// constants for the voltage-select setpoint register bank
`ifndef DVSSP_DEFINES_VH
`define DVSSP_DEFINES_VH

// register offsets on the serial register port
`define DVSSP_ADDR_M4_HIGH 8'h2a
`define DVSSP_ADDR_M1_SLEEP 8'h2b
`define DVSSP_ADDR_M2_SLEEP 8'h2c
`define DVSSP_ADDR_M3_SLEEP 8'h2d
`define DVSSP_ADDR_M4_SLEEP 8'h2e

// reset values and the value read at unmapped offsets
`define DVSSP_RST_HIGH 8'h78
`define DVSSP_RST_SLEEP 8'h1e
`define DVSSP_RDATA_UNMAPPED 8'h00

// code to millivolt mapping
`define DVSSP_MV_BASE 11'h0fa
`define DVSSP_MV_STEP 11'h005
`define DVSSP_MV_W 11

// field layout
`define DVSSP_CODE_W 8
`define DVSSP_ADDR_W 8
`define DVSSP_MASTERS 4

`endif

//--- hdl/dvssp_sync.v
// three-flop synchroniser with agreement filter for the select pin
`timescale 1ns/1ns
module dvssp_sync (
  input wire clk_sys, // system clock
  input wire rst_n, // synchronised reset, active low
  input wire pin_in, // asynchronous pin level
  output reg level_q // filtered level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; the level moves only once s2 and s3 agree
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule

//--- bench/dvssp_host.sv
// host model driving the select input
`timescale 1ns/1ns
module dvssp_host (
  input wire clk_sys, // clock
  input wire want, // level asked for
  output reg voltage_select_pin // select input
);
  initial voltage_select_pin = 1'b0;
  // moves a little after the edge, like a real host output
  always @(posedge clk_sys) voltage_select_pin <= #3 want;
endmodule

//--- bench/dvssp_props.sv
// port assertions for the setpoint bank
`timescale 1ns/1ns
module dvssp_props (
  input wire clk_sys, // clock
  input wire reset_n, // reset
  input wire voltage_select_pin, // pin
  input wire [7:0] reg_addr, // addr
  input wire [7:0] reg_wdata, // data
  input wire reg_wr, // write
  input wire reg_rd, // read
  input wire [23:0] ext_high_code, // ext
  input wire [7:0] reg_rdata, // rdata
  input wire reg_rvalid, // rvalid
  input wire voltage_select_level, // level
  input wire [31:0] target_code, // codes
  input wire [43:0] target_mv // mv
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_lvl(v);
    (voltage_select_level == v) [*3];
  endsequence
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  chk_rd_quiet: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
  chk_high_write: assert property (s_wr(8'h2a) ##0 s_lvl(1'b1)
    |-> target_code[31:24] == $past(reg_wdata, 2)) else $error("high code not applied");
  chk_sleep_write: assert property (s_wr(8'h2e) ##0 s_lvl(1'b0)
    |-> target_code[31:24] == $past(reg_wdata, 2)) else $error("sleep code not applied");
  chk_mv_low: assert property (target_mv[10:0] == 11'd250 + 11'd5 * target_code[7:0])
    else $error("mv map wrong");
  chk_mv_top: assert property (target_mv[43:33] == 11'd250 + 11'd5 * target_code[31:24])
    else $error("mv map wrong");
  chk_sel_follow: assert property ($rose(voltage_select_pin) ##0 voltage_select_pin [*6]
    |-> voltage_select_level) else $error("select level lags");
  chk_high_ext: assert property (voltage_select_level
    |-> target_code[23:0] == $past(ext_high_code)) else $error("high codes wrong");
endmodule
bind dvssp_top dvssp_props dvssp_props_inst (.*);

//--- bench/dvssp_top_bench.sv
// self-checking bench for the setpoint bank
`timescale 1ns/1ns
module dvssp_top_bench;
  reg clk_sys = 0;
  reg reset_n = 0;
  reg want = 0;
  wire pin;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 0;
  reg reg_rd = 0;
  reg [23:0] ext_high_code = 24'h332211;
  wire [7:0] reg_rdata;
  wire reg_rvalid;
  wire voltage_select_level;
  wire [31:0] target_code;
  wire [43:0] target_mv;
  integer err_count = 0;
  integer num_checks = 0;
  integer i;
  always #20 clk_sys = ~clk_sys;
  dvssp_host dvssp_host_inst (.clk_sys(clk_sys), .want(want), .voltage_select_pin(pin));
  dvssp_top dvssp_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .voltage_select_pin(pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .ext_high_code(ext_high_code), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .voltage_select_level(voltage_select_level), .target_code(target_code),
    .target_mv(target_mv));
  task chk(input string nm, input [43:0] seen, input [43:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys) #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys) #1;
    reg_wr = 0;
  endtask
  // the answer is launched at the edge that takes the strobe and stands one cycle
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clk_sys) #1;
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk_sys) #1;
    reg_rd = 0;
    chk("rvalid", reg_rvalid, 1'b1);
    chk("rdata", reg_rdata, e);
  endtask
  task tgt(input integer m, input [7:0] c);
    chk("code", target_code[m*8+:8], c);
    chk("mv", target_mv[m*11+:11], 11'd250 + 11'd5 * c);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset_n = 1;
    repeat (3) @(posedge clk_sys);
    rd(8'h2a, 8'h78);
    for (i = 8'h2b; i < 8'h2f; i++) rd(i[7:0], 8'h1e);
    rd(8'h30, 8'h00);
    chk("level", voltage_select_level, 1'b0);
    $display("test reset done");
    wr(8'h2e, 8'hff);
    wr(8'h2b, 8'h00);
    rd(8'h2e, 8'hff);
    tgt(3, 8'hff);
    tgt(0, 8'h00);
    $display("test sleep codes done");
    want = 1;
    repeat (8) @(posedge clk_sys);
    #1 tgt(3, 8'h78);
    tgt(0, 8'h11);
    chk("level", voltage_select_level, 1'b1);
    wr(8'h2a, 8'h9c);
    rd(8'h2a, 8'h9c);
    tgt(3, 8'h9c);
    $display("test high code done");
    want = 0;
    repeat (8) @(posedge clk_sys);
    #1 tgt(3, 8'hff);
    tgt(0, 8'h00);
    chk("level", voltage_select_level, 1'b0);
    $display("test return to sleep done");
    conclude;
  end
endmodule
